//--- common/mdsc_defines.svh
// Register offsets, field positions, reset values and event bit indices
`ifndef MDSC_DEFINES_SVH
`define MDSC_DEFINES_SVH
`define MDSC_OFF_MAIN_CTRL   4'h0
`define MDSC_OFF_PLL_CTRL    4'h1
`define MDSC_OFF_SYNC_SRC    4'h2
`define MDSC_OFF_ALARM_STAT  4'h3
`define MDSC_OFF_IRQ_STAT    4'h4
`define MDSC_OFF_IRQ_CLR     4'h5
`define MDSC_OFF_IRQ_EN      4'h6
`define MDSC_OFF_PHASE       4'h7
`define MDSC_BIT_CLKDIV_EN   0
`define MDSC_BIT_FIFO_SYNC   1
`define MDSC_BIT_PLL_ENA     0
`define MDSC_BIT_NDIV_EN     1
`define MDSC_BIT_DUAL        0
`define MDSC_BIT_SRC_SYNC    1
`define MDSC_BIT_DIV_OUTPUT_STROBE    2
`define MDSC_RST_MAIN        32'h0000_0001
`define MDSC_RST_ZERO        32'h0000_0000
`define MDSC_BAD_DATA        32'hdead_0bad
`define MDSC_EV_NDIV         0
`define MDSC_EV_DIV          1
`define MDSC_EV_PTR          2
`define MDSC_EV_ALARM        3
`endif

//--- common/mdsc_pkg.sv
// Types shared by the sync control block
package mdsc_pkg;
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } mdsc_req_t;
    typedef enum logic [2:0] {
        MDSC_IDLE = 3'b001,
        MDSC_RESP = 3'b010,
        MDSC_DONE = 3'b100
    } mdsc_bus_st_t;
endpackage

//--- src/mdsc_sync2.sv
// Two-flip-flop level synchroniser
module mdsc_sync2 (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic d,
    output logic      q
);
    logic meta_r;
    logic q_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            q_r    <= 1'b0;
        end else begin
            meta_r <= d;
            q_r    <= meta_r;
        end
    end
    assign q = q_r;
endmodule

//--- src/mdsc_top.sv
// Multi-device clock divider, PLL divider and FIFO pointer sync control
`include "mdsc_defines.svh"

// What this block does
// - Dual mode takes read-side pointer sync from output strobe, not input strobe.
// - Read and write pointers reset to a fixed offset, so latency stays constant.
// - Output strobe is sampled on converter clock; same clock domain required.
// - With PLL enabled, output strobe is generated internally from reference clock.
// - With PLL and N-divider sync enabled, SYNC rising edge resets the N divider.
// - In PLL mode no timing is assumed between SYNC and input strobe.
// - Single mode resets both pointers from one source, input strobe or SYNC.
// - Single mode read reset is resampled write reset; lags it by three cycles.
// - PLL with single mode never uses output strobe for read pointer.
// - Internal output strobe comes from N-divider output at phase detector rate.
module mdsc_top
    import mdsc_pkg::*;
#(
    parameter int          NDIV        = 8,
    parameter int          CLKDIV      = 4,
    parameter logic [2:0]  FIFO_OFFSET = 3'h4
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        output_strobe,
    input  wire logic        input_strobe,
    input  wire logic        sync_pin,
    input  wire logic        fifo_alarm,
    output logic             alarm_out,
    output logic             irq,
    output logic             clkdiv_tick,
    output logic             int_strobe,
    output logic [2:0]       wr_ptr,
    output logic [2:0]       rd_ptr
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic output_strobe_s;
    logic input_strobe_s;
    logic sync_s;
    logic alarm_s;
    mdsc_sync2 u_output_strobe  (.mclk(mclk), .rst_b(rst_b), .d(output_strobe), .q(output_strobe_s));
    mdsc_sync2 u_input_strobe  (.mclk(mclk), .rst_b(rst_b), .d(input_strobe),  .q(input_strobe_s));
    mdsc_sync2 u_sync  (.mclk(mclk), .rst_b(rst_b), .d(sync_pin),      .q(sync_s));
    mdsc_sync2 u_alarm (.mclk(mclk), .rst_b(rst_b), .d(fifo_alarm),    .q(alarm_s));

    function automatic logic rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0]   main_ctrl_r, main_ctrl_nxt;
    logic [31:0]   pll_ctrl_r, pll_ctrl_nxt;
    logic [31:0]   sync_src_r, sync_src_nxt;
    logic [3:0]    irq_stat_r, irq_stat_nxt;
    logic [3:0]    irq_en_r, irq_en_nxt;
    logic [31:0]   rdata_r, rdata_nxt;
    logic          wait_r, wait_nxt;
    logic          irq_r, irq_nxt;
    logic          alarm_r, alarm_nxt;
    mdsc_bus_st_t  bst_r, bst_nxt;
    mdsc_req_t     req;

    logic          pll_ena;
    logic          dual_mode;
    logic [3:0]    events;

    assign req.read      = avs_read;
    assign req.write     = avs_write;
    assign req.address   = avs_address;
    assign req.writedata = avs_writedata;

    assign pll_ena   = pll_ctrl_r[`MDSC_BIT_PLL_ENA];
    assign dual_mode = sync_src_r[`MDSC_BIT_DUAL];

    ////////////////////////////////////////////////////////////////////////
    // Divider and pointer state
    logic [7:0] ndiv_r, ndiv_nxt;
    logic [7:0] cdiv_r, cdiv_nxt;
    logic [2:0] wr_r, wr_nxt;
    logic [2:0] rd_r, rd_nxt;
    logic       input_strobe_d_r, sync_d_r, output_strobe_d_r, istb_d_r;
    logic       wrst_r, wrst_nxt;
    logic [1:0] rrst_r, rrst_nxt;
    logic       tick_r, tick_nxt;
    logic       istb_r, istb_nxt;

    logic       sync_rise, input_strobe_rise, output_strobe_rise, istb_rise;
    logic       rd_strobe;
    logic       div_src;
    logic       wr_sync;

    assign sync_rise = rise(sync_s, sync_d_r);
    assign input_strobe_rise = rise(input_strobe_s, input_strobe_d_r);
    assign output_strobe_rise = rise(output_strobe_s, output_strobe_d_r);
    assign istb_rise = rise(istb_r, istb_d_r);
    // Internal strobe in PLL mode, pin strobe otherwise
    assign rd_strobe = pll_ena ? istb_rise : output_strobe_rise;
    assign div_src   = sync_src_r[`MDSC_BIT_DIV_OUTPUT_STROBE] ? rd_strobe : sync_rise;
    // Single mode write reset source: input strobe or SYNC
    assign wr_sync   = sync_src_r[`MDSC_BIT_SRC_SYNC] ? sync_rise : input_strobe_rise;

    always_comb begin
        ndiv_nxt = (ndiv_r == 8'(NDIV - 1)) ? 8'h00 : ndiv_r + 8'h01;
        if (pll_ena && pll_ctrl_r[`MDSC_BIT_NDIV_EN] && sync_rise) begin
            ndiv_nxt = 8'h00;
        end
        // Strobe taken from the N divider output
        istb_nxt = (ndiv_r < 8'(NDIV / 2));
        cdiv_nxt = (cdiv_r == 8'(CLKDIV - 1)) ? 8'h00 : cdiv_r + 8'h01;
        if (main_ctrl_r[`MDSC_BIT_CLKDIV_EN] && div_src) begin
            cdiv_nxt = 8'h00;
        end
        tick_nxt = (cdiv_nxt == 8'h00);
        wr_nxt   = wr_r + 3'h1;
        rd_nxt   = rd_r + 3'h1;
        wrst_nxt = 1'b0;
        rrst_nxt = {rrst_r[0], 1'b0};
        if (main_ctrl_r[`MDSC_BIT_FIFO_SYNC]) begin
            if (dual_mode) begin
                if (input_strobe_rise) begin
                    wr_nxt = FIFO_OFFSET;
                end
                if (rd_strobe) begin
                    rd_nxt = 3'h0;
                end
            end else begin
                if (wr_sync) begin
                    wr_nxt   = FIFO_OFFSET;
                    wrst_nxt = 1'b1;
                end
                // Read reset is the resampled write reset, never the strobe
                rrst_nxt = {rrst_r[0], wrst_r};
                if (rrst_r[1]) begin
                    rd_nxt = 3'h0;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ndiv_r   <= 8'h00;
            cdiv_r   <= 8'h00;
            wr_r     <= 3'h0;
            rd_r     <= 3'h0;
            input_strobe_d_r <= 1'b0;
            sync_d_r <= 1'b0;
            output_strobe_d_r <= 1'b0;
            istb_d_r <= 1'b0;
            wrst_r   <= 1'b0;
            rrst_r   <= 2'h0;
            tick_r   <= 1'b0;
            istb_r   <= 1'b0;
        end else begin
            ndiv_r   <= ndiv_nxt;
            cdiv_r   <= cdiv_nxt;
            wr_r     <= wr_nxt;
            rd_r     <= rd_nxt;
            input_strobe_d_r <= input_strobe_s;
            sync_d_r <= sync_s;
            output_strobe_d_r <= output_strobe_s;
            istb_d_r <= istb_r;
            wrst_r   <= wrst_nxt;
            rrst_r   <= rrst_nxt;
            tick_r   <= tick_nxt;
            istb_r   <= istb_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events
    assign events[`MDSC_EV_NDIV]  = pll_ena && pll_ctrl_r[`MDSC_BIT_NDIV_EN] && sync_rise;
    assign events[`MDSC_EV_DIV]   = main_ctrl_r[`MDSC_BIT_CLKDIV_EN] && div_src;
    assign events[`MDSC_EV_PTR]   = main_ctrl_r[`MDSC_BIT_FIFO_SYNC]
                                    && (dual_mode ? rd_strobe : rrst_r[1]);
    assign events[`MDSC_EV_ALARM] = alarm_s;

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave, one wait cycle per access
    always_comb begin
        main_ctrl_nxt = main_ctrl_r;
        pll_ctrl_nxt  = pll_ctrl_r;
        sync_src_nxt  = sync_src_r;
        irq_en_nxt    = irq_en_r;
        irq_stat_nxt  = irq_stat_r;
        rdata_nxt     = rdata_r;
        wait_nxt      = 1'b1;
        bst_nxt       = bst_r;
        case (bst_r)
            MDSC_IDLE: begin
                if (req.read || req.write) begin
                    bst_nxt  = MDSC_RESP;
                    wait_nxt = 1'b0;
                    // Read word captured now so it stands when waitrequest is seen low
                    case (req.address)
                        `MDSC_OFF_MAIN_CTRL:  rdata_nxt = main_ctrl_r;
                        `MDSC_OFF_PLL_CTRL:   rdata_nxt = pll_ctrl_r;
                        `MDSC_OFF_SYNC_SRC:   rdata_nxt = sync_src_r;
                        `MDSC_OFF_ALARM_STAT: rdata_nxt = {31'h0, alarm_s};
                        `MDSC_OFF_IRQ_STAT:   rdata_nxt = {28'h0, irq_stat_r};
                        `MDSC_OFF_IRQ_CLR:    rdata_nxt = `MDSC_RST_ZERO;
                        `MDSC_OFF_IRQ_EN:     rdata_nxt = {28'h0, irq_en_r};
                        `MDSC_OFF_PHASE:      rdata_nxt = {16'h0, cdiv_r, 2'h0, rd_r, wr_r};
                        default:              rdata_nxt = `MDSC_BAD_DATA;
                    endcase
                end
            end
            MDSC_RESP: begin
                bst_nxt = MDSC_DONE;
                if (req.write) begin
                    case (req.address)
                        `MDSC_OFF_MAIN_CTRL: main_ctrl_nxt = req.writedata;
                        `MDSC_OFF_PLL_CTRL:  pll_ctrl_nxt  = req.writedata;
                        `MDSC_OFF_SYNC_SRC:  sync_src_nxt  = req.writedata;
                        `MDSC_OFF_IRQ_CLR:   irq_stat_nxt  = irq_stat_r & ~req.writedata[3:0];
                        `MDSC_OFF_IRQ_EN:    irq_en_nxt    = req.writedata[3:0];
                        default:             irq_stat_nxt  = irq_stat_r;
                    endcase
                end
            end
            MDSC_DONE: begin
                bst_nxt = MDSC_IDLE;
            end
            default: begin
                bst_nxt = MDSC_IDLE;
            end
        endcase
        // Set wins over clear
        irq_stat_nxt = irq_stat_nxt | events;
        irq_nxt      = |(irq_stat_nxt & irq_en_nxt);
        alarm_nxt    = alarm_s;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            main_ctrl_r <= `MDSC_RST_MAIN;
            pll_ctrl_r  <= `MDSC_RST_ZERO;
            sync_src_r  <= `MDSC_RST_ZERO;
            irq_stat_r  <= 4'h0;
            irq_en_r    <= 4'h0;
            rdata_r     <= `MDSC_RST_ZERO;
            wait_r      <= 1'b1;
            irq_r       <= 1'b0;
            alarm_r     <= 1'b0;
            bst_r       <= MDSC_IDLE;
        end else begin
            main_ctrl_r <= main_ctrl_nxt;
            pll_ctrl_r  <= pll_ctrl_nxt;
            sync_src_r  <= sync_src_nxt;
            irq_stat_r  <= irq_stat_nxt;
            irq_en_r    <= irq_en_nxt;
            rdata_r     <= rdata_nxt;
            wait_r      <= wait_nxt;
            irq_r       <= irq_nxt;
            alarm_r     <= alarm_nxt;
            bst_r       <= bst_nxt;
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign irq             = irq_r;
    assign alarm_out       = alarm_r;
    assign clkdiv_tick     = tick_r;
    assign int_strobe      = istb_r;
    assign wr_ptr          = wr_r;
    assign rd_ptr          = rd_r;
endmodule

//--- testbench/mdsc_dist_model.sv
// Clock distribution and data source model driving the sync pins
module mdsc_dist_model (
    input  wire logic mclk,
    output logic      output_strobe,
    output logic      input_strobe,
    output logic      sync_pin,
    output logic      fifo_alarm
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] pins_r = 3'h0;
    assign {sync_pin, input_strobe, output_strobe} = pins_r;
    initial fifo_alarm = 1'b0;
    // Pins launched on the converter clock edge
    task automatic pulse(input logic [2:0] mask, input int lag);
        repeat (lag) @(posedge mclk);
        @(posedge mclk);
        pins_r <= pins_r | mask;
        repeat (4) @(posedge mclk);
        pins_r <= pins_r & ~mask;
        repeat (6) @(posedge mclk);
    endtask
    task automatic set_alarm(input logic v);
        @(posedge mclk);
        fifo_alarm <= v;
    endtask
endmodule

//--- testbench/mdsc_top_assertions.sv
// Port-level checks for the sync control block
module mdsc_top_checker #(
    parameter int NDIV   = 8,
    parameter int CLKDIV = 4
) (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        output_strobe,
    input wire logic        input_strobe,
    input wire logic        sync_pin,
    input wire logic        fifo_alarm,
    input wire logic        alarm_out,
    input wire logic        irq,
    input wire logic        clkdiv_tick,
    input wire logic        int_strobe,
    input wire logic [2:0]  wr_ptr,
    input wire logic [2:0]  rd_ptr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_answer; ($rose(avs_read) || $rose(avs_write)) |=> !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("late answer");
    property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_one: assert property (p_one) else $error("long answer");
    property p_bad; avs_read && !avs_waitrequest && avs_address[3] |-> avs_readdata == 32'hdead_0bad; endproperty
    a_bad: assert property (p_bad) else $error("bad unmapped read");
    property p_alarm; alarm_out == $past(fifo_alarm, 3); endproperty
    a_alarm: assert property (p_alarm) else $error("alarm pin lag");
    property p_wr; ($stable(input_strobe) && $stable(sync_pin))[*6] |-> wr_ptr == $past(wr_ptr) + 3'h1; endproperty
    a_wr: assert property (p_wr) else $error("write pointer step");
    property p_tick; ($stable(output_strobe) && $stable(sync_pin))[*5] ##0 clkdiv_tick
        ##1 ($stable(output_strobe) && $stable(sync_pin))[*3] |=> clkdiv_tick; endproperty
    a_tick: assert property (p_tick) else $error("divider period");
    property p_istb; $rose(int_strobe) |-> int_strobe[*4]; endproperty
    a_istb: assert property (p_istb) else $error("strobe width");
    property p_mask; avs_write && !avs_waitrequest && avs_address == 4'h6
        && avs_writedata[3:0] == 4'h0 |-> ##2 !irq; endproperty
    a_mask: assert property (p_mask) else $error("irq not masked");
endmodule
bind mdsc_top mdsc_top_checker #(.NDIV(NDIV), .CLKDIV(CLKDIV)) u_chk (
    .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .output_strobe(output_strobe),
    .input_strobe(input_strobe), .sync_pin(sync_pin), .fifo_alarm(fifo_alarm),
    .alarm_out(alarm_out), .irq(irq), .clkdiv_tick(clkdiv_tick), .int_strobe(int_strobe),
    .wr_ptr(wr_ptr), .rd_ptr(rd_ptr));

//--- testbench/test_multi_device_sync_control.sv
// Bus-driven bench for the sync control block
module test_multi_device_sync_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, rst_b, avs_read, avs_write, avs_waitrequest, irq, alarm_out;
    logic        output_strobe, input_strobe, sync_pin, fifo_alarm, clkdiv_tick, int_strobe;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [2:0]  wr_ptr, rd_ptr, g, g0;
    int          bad_count, checks_done, n;
    always #25 mclk = ~mclk;
    mdsc_top #(.NDIV(8), .CLKDIV(4), .FIFO_OFFSET(3'h4)) u_dut (
        .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .output_strobe(output_strobe),
        .input_strobe(input_strobe), .sync_pin(sync_pin), .fifo_alarm(fifo_alarm),
        .alarm_out(alarm_out), .irq(irq), .clkdiv_tick(clkdiv_tick),
        .int_strobe(int_strobe), .wr_ptr(wr_ptr), .rd_ptr(rd_ptr));
    mdsc_dist_model u_dist (.mclk(mclk), .output_strobe(output_strobe),
        .input_strobe(input_strobe), .sync_pin(sync_pin), .fifo_alarm(fifo_alarm));
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (bad_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin @(posedge mclk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k >= 50) begin bad_count++; close_out(); end
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin bad_count++; $display("MISMATCH %0t word %h not %h", $time, got, exp); end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin bad_count++; $display("MISMATCH %0t bit %b not %b", $time, got, exp); end
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        close_out();
    end
    initial begin
        mclk = 1'b0; rst_b = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
        avs_address = 4'h0; avs_writedata = 32'h0; bad_count = 0; checks_done = 0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, i[3:0], 32'h0);
            chk_w(rd, i == 0 ? 32'h1 : 32'h0);
        end
        bus(1'b0, 4'h9, 32'h0);
        chk_w(rd, 32'hdead_0bad);
        bus(1'b1, 4'h2, 32'h5);
        bus(1'b1, 4'h0, 32'h3);
        bus(1'b1, 4'h6, 32'hf);
        u_dist.pulse(3'h2, 0);
        bus(1'b0, 4'h4, 32'h0);
        chk_w(rd, 32'h0);
        u_dist.pulse(3'h1, 3);
        bus(1'b0, 4'h4, 32'h0);
        chk_w(rd, 32'h6);
        chk_b(irq, 1'b1);
        bus(1'b0, 4'h7, 32'h0);
        g0 = rd[2:0] - rd[5:3];
        chk_w({29'h0, wr_ptr - rd_ptr}, {29'h0, g0});
        repeat (11) @(posedge mclk);
        bus(1'b0, 4'h7, 32'h0);
        g = rd[2:0] - rd[5:3];
        chk_w({29'h0, g}, {29'h0, g0});
        u_dist.set_alarm(1'b1);
        repeat (5) @(posedge mclk);
        bus(1'b0, 4'h3, 32'h0);
        chk_w(rd, 32'h1);
        chk_b(alarm_out, 1'b1);
        u_dist.set_alarm(1'b0);
        bus(1'b1, 4'h0, 32'h2);
        bus(1'b1, 4'h5, 32'hf);
        u_dist.pulse(3'h1, 0);
        bus(1'b0, 4'h4, 32'h0);
        chk_w(rd & 32'h2, 32'h0);
        bus(1'b1, 4'h6, 32'h0);
        @(negedge mclk);
        chk_b(irq, 1'b0);
        bus(1'b1, 4'h6, 32'hf);
        bus(1'b1, 4'h1, 32'h3);
        bus(1'b1, 4'h5, 32'hf);
        u_dist.pulse(3'h4, 2);
        bus(1'b0, 4'h4, 32'h0);
        chk_w(rd & 32'h1, 32'h1);
        n = 0;
        do begin @(negedge mclk); n++; end while (int_strobe !== 1'b1 && n < 20);
        chk_b(int_strobe, 1'b1);
        if (n >= 20) close_out();
        bus(1'b1, 4'h1, 32'h1);
        bus(1'b1, 4'h5, 32'hf);
        u_dist.pulse(3'h4, 1);
        bus(1'b0, 4'h4, 32'h0);
        chk_w(rd & 32'h1, 32'h0);
        bus(1'b1, 4'h1, 32'h0);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, 4'h2, i == 0 ? 32'h0 : 32'h2);
            bus(1'b1, 4'h5, 32'hf);
            u_dist.pulse(i == 0 ? 3'h2 : 3'h4, i);
            bus(1'b0, 4'h4, 32'h0);
            chk_w(rd & 32'h4, 32'h4);
        end
        bus(1'b1, 4'h1, 32'h1);
        repeat (20) @(posedge mclk);
        bus(1'b0, 4'h7, 32'h0);
        g = rd[2:0] - rd[5:3] - 3'h4;
        chk_b(g >= 3'h1 && g <= 3'h3, 1'b1);
        close_out();
    end
endmodule
